// ### dv/cfb_checker.sv
module cfb_checker
  import cfb_pkg::*;
#(
  parameter int DW      = 32,
  parameter int RDY_MAX = 1000,
  parameter int REL_CYC = 1950
) (
  // Clock, reset and channel
  input wire logic          i_clk,
  input wire logic          i_arst_n,
  input wire cfb_pins_type  i_pins,
  input wire logic [DW-1:0] i_data,
  // Design outputs
  input wire logic          o_arbitrate_grant_phase,
  input wire logic [3:0]    o_granted_level,
  input wire logic          o_release_timeout,
  input wire logic          o_card_channel_ready_oe,
  input wire logic [DW-1:0] o_wr_data,
  input wire logic          o_wr_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic ph   = o_arbitrate_grant_phase;
  wire logic oe   = o_card_channel_ready_oe;
  // Status, hold and command all released
  wire logic transfer_end_condition  = &i_pins[10:7];
  wire logic stat = !(&i_pins[10:9]);
  logic [15:0] eot_r, arb_r, oe_r, req_r;
  logic        adl_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {eot_r, arb_r, oe_r, req_r, adl_r} <= '0;
    end else begin
      eot_r <= transfer_end_condition ? eot_r + 16'h1 : 16'h0;
      arb_r <= ph ? arb_r + 16'h1 : 16'h0;
      oe_r  <= oe ? oe_r + 16'h1 : 16'h0;
      req_r <= i_pins.channel_request_n ? 16'h0 : req_r + 16'h1;
      adl_r <= stat && (adl_r || !i_pins.address_latch_strobe_n);
    end
  end
  property p_arb; $fell(ph) |-> arb_r >= 16'h19; endproperty
  a_arb: assert property (p_arb) else $error("arbitrate too short");
  property p_gap; $rose(ph) && req_r < REL_CYC |-> eot_r >= 16'h8; endproperty
  a_gap: assert property (p_gap) else $error("arbitrate too soon");
  property p_busy; !transfer_end_condition && !ph && req_r < REL_CYC |=> !ph; endproperty
  a_busy: assert property (p_busy) else $error("arbitrate in transfer");
  property p_lvl; $fell(ph) |=> o_granted_level == $past(i_pins.priority_lines, 4); endproperty
  a_lvl: assert property (p_lvl) else $error("wrong level");
  property p_rdy; $rose(oe) |-> adl_r; endproperty
  a_rdy: assert property (p_rdy) else $error("ready before strobe");
  property p_rmax; oe |-> oe_r <= RDY_MAX; endproperty
  a_rmax: assert property (p_rmax) else $error("ready held too long");
  property p_wd; o_wr_valid |-> o_wr_data == $past(i_data, 4); endproperty
  a_wd: assert property (p_wd) else $error("wrong write data");
  property p_to; o_release_timeout |-> req_r >= REL_CYC; endproperty
  a_to: assert property (p_to) else $error("early timeout");
endmodule : cfb_checker

bind cfb_central cfb_checker #(.DW(DW), .RDY_MAX(RDY_MAX), .REL_CYC(REL_CYC)) cfb_checker_i (.*);

// ### dv/cfb_dev_model.sv
module cfb_dev_model
  import cfb_pkg::*;
(
  // Clock and watched outputs
  input  wire logic    i_clk,
  input  wire logic    i_phase,
  input  wire logic    i_ready_oe,
  // Driven channel
  output cfb_pins_type o_pins,
  output logic [31:0]  o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int held;
  logic fair_en  = 1'b1;
  logic inactive = 1'b0;
  logic stalled  = 1'b0;
  // All released; the level lines rest at the pull-up value
  initial o_pins = 11'h7EF;
  initial o_data = 32'h0;
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic until_ph(input logic v);
    int i;
    for (i = 0; i < 400 && i_phase !== v; i++) cyc(1);
    if (i == 400) stalled = 1'b1;
  endtask : until_ph
  // Request, then end the tenure with an aborted cycle
  task automatic request(input logic [3:0] lvl);
    // Exit waits a fixed 3 cycles after request idle only, never on the phase
    if (inactive) begin
      cyc(3);
    end
    inactive = 1'b0;
    // Start late enough that status cannot end before 145 ns after grant
    cyc(15);
    o_pins.channel_request_n = 1'b0;
    o_pins.status_zero_n = 1'b0;
    cyc(22);
    o_pins.status_zero_n = 1'b1;
    until_ph(1'b1);
    cyc(2);
    o_pins.priority_lines = lvl;
    until_ph(1'b0);
    cyc(2);
    o_pins.channel_request_n = 1'b1;
    o_pins.priority_lines = 4'hF;
  endtask : request
  task automatic write(input logic mem, input logic [31:0] d);
    held = 0;
    cyc(12);
    o_pins.memory_or_io_select = mem;
    cyc(3);
    o_pins.status_zero_n = 1'b0;
    cyc(4);
    o_pins.address_latch_strobe_n = 1'b0;
    o_data = d;
    cyc(10);
    o_pins.transfer_command_n = 1'b0;
    o_pins.address_latch_strobe_n = 1'b1;
    cyc(8);
    while (i_ready_oe === 1'b1 && held < 100) begin
      held++;
      cyc(1);
    end
    if (held == 100) stalled = 1'b1;
    o_pins.status_zero_n = 1'b1;
    cyc(15);
    o_pins.transfer_command_n = 1'b1;
    cyc(8);
    // Released bus: never leave the old word standing
    o_data = ~d;
  endtask : write
  // Burst owner that ignores a request until cut off
  task automatic hog();
    o_pins.multi_cycle_hold_n = 1'b0;
    o_pins.channel_request_n = 1'b0;
    until_ph(1'b1);
    o_pins.multi_cycle_hold_n = 1'b1;
    o_pins.channel_request_n = 1'b1;
    inactive = fair_en;
  endtask : hog
endmodule : cfb_dev_model

// ### dv/tb_channel_fairness_and_basic_transfer.sv
module tb_channel_fairness_and_basic_transfer;
  import cfb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk, arst_n, sel, wt, ph, to, oe, wv, wm, got_m;
  logic [3:0]   lvl;
  logic [31:0]  dat, wd, got_d;
  cfb_pins_type pins;
  int           mismatches = 0, n_tests = 0, n_wr = 0, n_to = 0;
  // Short counts keep the timeout and ready limit cases fast
  cfb_central #(.DW(32), .RDY_MAX(20), .REL_CYC(40)) cfb_central_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_pins(pins), .i_data(dat),
    .i_slave_sel(sel), .i_slave_wait(wt), .o_arbitrate_grant_phase(ph),
    .o_granted_level(lvl), .o_release_timeout(to), .o_card_channel_ready_oe(oe),
    .o_wr_data(wd), .o_wr_is_memory(wm), .o_wr_valid(wv));
  cfb_dev_model cfb_dev_model_i (
    .i_clk(clk), .i_phase(ph), .i_ready_oe(oe), .o_pins(pins), .o_data(dat));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    if (wv === 1'b1) begin
      got_d = wd;
      got_m = wm;
      n_wr++;
    end
    if (to === 1'b1) n_to++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wait_ph(input logic v);
    int i;
    for (i = 0; i < 400 && ph !== v; i++) @(negedge clk);
    if (i == 400) begin
      mismatches++;
      $display("[FAIL] %0t: phase wait ran out", $time);
      tally_and_finish();
    end
  endtask : wait_ph
  task automatic model_ok();
    if (cfb_dev_model_i.stalled === 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t: model wait ran out", $time);
      tally_and_finish();
    end
  endtask : model_ok
  task automatic t_reset();
    check(32'({ph, oe, wv}), 32'h4);
    wait_ph(1'b0);
    check(32'(lvl), 32'hF);
    $display("reset test done");
  endtask : t_reset
  task automatic t_arb(input logic [3:0] l);
    int n0;
    n0 = n_wr;
    cfb_dev_model_i.request(l);
    model_ok();
    check(32'(lvl), 32'(l));
    check(32'(n_wr), 32'(n0));
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_write(input logic m, input logic [31:0] d, input logic w);
    int n0;
    n0 = n_wr;
    sel = 1'b1;
    wt = w;
    cfb_dev_model_i.write(m, d);
    model_ok();
    sel = 1'b0;
    wt = 1'b0;
    check(32'(n_wr), 32'(n0 + 1));
    check(got_d, d);
    check(32'(got_m), 32'(m));
    check(32'(cfb_dev_model_i.held > 0), 32'(w));
    wait_ph(1'b1);
    wait_ph(1'b0);
    $display("write test done");
  endtask : t_write
  task automatic t_timeout();
    int n0;
    n0 = n_to;
    cfb_dev_model_i.hog();
    model_ok();
    repeat (2) @(negedge clk);
    check(32'(n_to), 32'(n0 + 1));
    check(32'(ph), 32'h1);
    wait_ph(1'b0);
    $display("timeout test done");
  endtask : t_timeout
  initial begin
    arst_n = 1'b0;
    sel = 1'b0;
    wt = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_arb(4'h5);
    t_write(1'b1, 32'hA5C30F96, 1'b1);
    t_write(1'b0, 32'h5A3CF069, 1'b0);
    t_arb(4'h0);
    t_timeout();
    t_arb(4'h3);
    tally_and_finish();
  end
endmodule : tb_channel_fairness_and_basic_transfer

// ### include/cfb_consts.svh
`ifndef CFB_CONSTS_SVH
`define CFB_CONSTS_SVH

// Clock rate and the minimum-time to cycle conversion (rounds up)
`define CFB_CLK_MHZ        250
`define CFB_CYC_MIN(ns)    (((ns) * `CFB_CLK_MHZ + 999) / 1000)

// Timing figures in ns
`define CFB_EOT_TO_ARB_NS  30
`define CFB_ARB_HOLD_NS    100
`define CFB_PRIO_STABLE_NS 10
`define CFB_RELEASE_NS     7800

// Derived cycle counts
`define CFB_EOT_TO_ARB_CYC  `CFB_CYC_MIN(`CFB_EOT_TO_ARB_NS)
`define CFB_ARB_HOLD_CYC    `CFB_CYC_MIN(`CFB_ARB_HOLD_NS)
`define CFB_PRIO_STABLE_CYC `CFB_CYC_MIN(`CFB_PRIO_STABLE_NS)
`define CFB_RELEASE_CYC     ((`CFB_RELEASE_NS * `CFB_CLK_MHZ) / 1000)

// Default level of the channel when nobody requests
`define CFB_DEFAULT_LEVEL  4'hF

// Reset values
`define CFB_RST_PHASE      1'b1

`endif

// ### include/cfb_pkg.sv
package cfb_pkg;

  // Channel pins seen by the central point and the responding slave
  typedef struct packed {
    logic       status_zero_n;
    logic       status_one_n;
    logic       multi_cycle_hold_n;
    logic       transfer_command_n;
    logic       channel_request_n;
    logic       address_latch_strobe_n;
    logic       memory_or_io_select;
    logic [3:0] priority_lines;
  } cfb_pins_type;

  typedef enum logic [1:0] {
    ST_GRANT,
    ST_EOT_HOLD,
    ST_ARBITRATE
  } cfb_state_type;

endpackage : cfb_pkg

// ### rtl/cfb_central.sv
// Function
// R1: Bursting participants implement fairness mechanism
// R2: Owner releases within 7.8 us of request
// R3: Fair releaser enters inactive state if requested
// R4: Inactive participant neither requests nor arbitrates
// R5: Exit inactive after request idle plus 10 ns
// R6: Inactive exit ignores arbitrate/grant phase
// R7: Burster asserts hold within 50 ns of grant
// R8: Winner drops request within 50 ns of grant
// R9: Arbitrate phase lasts at least 100 ns
// R10: Arbitrate starts 30 ns after end; end held
// R11: Priority drivers switch within 50 ns
// R12: Priority lines stable 10 ns before grant
// R13: First command 115 ns, status 145 ns after grant
// R14: Early DMA address adds 30 ns before sampling
// R15: Aborted cycle status pulse at least 85 ns
// R16: Data moves only within command; space select
// R17: Write signals driven in documented order
// R18: Slave returns select and port size decodes
// R19: Slave stretches cycle via unlatched ready decode
// R20: Slave latches decodes at strobe or command
// R21: Master waits on ready; slave bounds hold
// R22: Status drops at cycle end, address may change
// R23: Abort skips strobe and command, drops hold
// R24: Transfer end is last trailing control edge
// R25: Levels 0 highest to F; bitwise backoff
// R26: Fairness setting comes out of reset enabled
`include "cfb_consts.svh"

module cfb_central
  import cfb_pkg::*;
#(
  parameter int DW       = 32,
  parameter int RDY_MAX  = 1000,
  parameter int REL_CYC  = `CFB_RELEASE_CYC
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // Channel pins
  input  wire cfb_pins_type  i_pins,
  input  wire logic [DW-1:0] i_data,
  // Local slave control
  input  wire logic          i_slave_sel,
  input  wire logic          i_slave_wait,
  // Arbitration
  output      logic          o_arbitrate_grant_phase,
  output      logic [3:0]    o_granted_level,
  output      logic          o_release_timeout,
  // Slave ready, open drain: value is always low
  output      logic          o_card_channel_ready_oe,
  // Received write data
  output      logic [DW-1:0] o_wr_data,
  output      logic          o_wr_is_memory,
  output      logic          o_wr_valid
);

  localparam int TW = 12;

  // Two-stage synchronisers for every pin input
  cfb_pins_type  pins_s1_r;
  cfb_pins_type  pins_r;
  logic [DW-1:0] data_s1_r;
  logic [DW-1:0] data_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins_s1_r <= '1;
      pins_r    <= '1;
      data_s1_r <= '0;
      data_r    <= '0;
    end else begin
      pins_s1_r <= i_pins;
      pins_r    <= pins_s1_r;
      data_s1_r <= i_data;
      data_r    <= data_s1_r;
    end
  end

  // Decoding
  wire status_act = !pins_r.status_zero_n || !pins_r.status_one_n;
  wire ctrl_act   = status_act || !pins_r.multi_cycle_hold_n || !pins_r.transfer_command_n;
  wire eot_now    = !ctrl_act; // R24
  wire req_act    = !pins_r.channel_request_n;

  // Arbitration state
  cfb_state_type state_r;
  cfb_state_type state_nxt;
  logic          busy_seen_r;
  logic [3:0]    prio_prev_r;
  logic          eot_done;
  logic          hold_done;
  logic          stable_done;
  logic          rel_done;

  cfb_timer #(.W(TW)) u_eot_timer (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (state_r == ST_EOT_HOLD),
    .i_limit  (TW'(`CFB_EOT_TO_ARB_CYC)),
    .o_done   (eot_done)
  );

  cfb_timer #(.W(TW)) u_hold_timer (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (state_r == ST_ARBITRATE),
    .i_limit  (TW'(`CFB_ARB_HOLD_CYC)),
    .o_done   (hold_done)
  );

  // Restarts on any change, so only a settled bus lets grant through
  cfb_timer #(.W(TW)) u_stable_timer (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    ((state_r == ST_ARBITRATE) && (pins_r.priority_lines == prio_prev_r)),
    .i_limit  (TW'(`CFB_PRIO_STABLE_CYC)),
    .o_done   (stable_done)
  );

  // Owner that ignores a request too long is overridden
  cfb_timer #(.W(TW)) u_rel_timer (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    ((state_r == ST_GRANT) && req_act && busy_seen_r),
    .i_limit  (TW'(REL_CYC)),
    .o_done   (rel_done)
  );

  wire go_grant = hold_done && stable_done; // R9 R12

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_GRANT: begin
        if (rel_done) begin
          state_nxt = ST_ARBITRATE; // R2
        end else if (busy_seen_r && eot_now) begin
          state_nxt = ST_EOT_HOLD;
        end
      end
      ST_EOT_HOLD: begin
        if (!eot_now) begin
          state_nxt = ST_GRANT; // R10
        end else if (eot_done) begin
          state_nxt = ST_ARBITRATE; // R10
        end
      end
      ST_ARBITRATE: begin
        if (go_grant) begin
          state_nxt = ST_GRANT;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r                 <= ST_ARBITRATE;
      busy_seen_r             <= 1'b0;
      prio_prev_r             <= `CFB_DEFAULT_LEVEL;
      o_arbitrate_grant_phase <= `CFB_RST_PHASE;
      o_granted_level         <= `CFB_DEFAULT_LEVEL;
      o_release_timeout       <= 1'b0;
    end else begin
      state_r                 <= state_nxt;
      busy_seen_r             <= (state_r == ST_ARBITRATE) ? 1'b0 : (busy_seen_r || ctrl_act);
      prio_prev_r             <= pins_r.priority_lines;
      o_arbitrate_grant_phase <= (state_nxt == ST_ARBITRATE);
      o_release_timeout       <= (state_r == ST_GRANT) && rel_done;
      if ((state_r == ST_ARBITRATE) && go_grant) begin
        o_granted_level <= pins_r.priority_lines; // R25
      end
    end
  end

  // Responding slave: ready may only be pulled after the latch strobe
  logic rdy_done;
  logic adl_seen_r;
  logic cmd_prev_r;
  logic wr_cyc_r;
  logic mem_cyc_r;

  wire sel_act  = i_slave_sel && status_act;
  wire cmd_rise = !cmd_prev_r && pins_r.transfer_command_n;
  wire cmd_fall = cmd_prev_r && !pins_r.transfer_command_n;
  wire rdy_want = sel_act && adl_seen_r && i_slave_wait;

  // Times the wish, not the pull, so a spent limit stays spent until select, wait or status drops
  cfb_timer #(.W(TW)) u_rdy_timer (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (rdy_want),
    .i_limit  (TW'(RDY_MAX)),
    .o_done   (rdy_done)
  );

  wire rdy_nxt  = rdy_want && !rdy_done; // R21

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      adl_seen_r              <= 1'b0;
      cmd_prev_r              <= 1'b1;
      wr_cyc_r                <= 1'b0;
      mem_cyc_r               <= 1'b0;
      o_card_channel_ready_oe <= 1'b0;
      o_wr_data               <= '0;
      o_wr_is_memory          <= 1'b0;
      o_wr_valid              <= 1'b0;
    end else begin
      adl_seen_r              <= status_act && (adl_seen_r || !pins_r.address_latch_strobe_n);
      cmd_prev_r              <= pins_r.transfer_command_n;
      o_card_channel_ready_oe <= rdy_nxt;
      o_wr_valid              <= cmd_rise && wr_cyc_r; // R16
      if (cmd_fall) begin
        wr_cyc_r  <= sel_act && !pins_r.status_zero_n && pins_r.status_one_n;
        mem_cyc_r <= pins_r.memory_or_io_select; // R16
      end
      if (cmd_rise && wr_cyc_r) begin
        o_wr_data      <= data_r; // R16
        o_wr_is_memory <= mem_cyc_r;
      end
    end
  end

endmodule : cfb_central

// ### rtl/cfb_timer.sv
module cfb_timer #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // Control
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_limit,
  // Status
  output      logic         o_done
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // Restarts whenever run drops, saturates at the limit
  assign count_nxt = !i_run ? '0 : (count_r == i_limit) ? count_r : count_r + 1'b1;
  assign o_done    = i_run && (count_r == i_limit);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : cfb_timer
